// ### cbbu_pkg.sv
// Contract
// - Signed and equality register-register branch conditions.
// - Unsigned register compares for less or greater-equal.
// - Small-offset zero compares test source b signed.
// - Large-offset zero compares test source a.
// - Taken branch squashes the following instruction.
// - Any instruction may follow a branch immediately.
// - Unconditional short jump always loads target.
// - Breakpoint raises exception, code field ignored.
// - Reverse bits within each byte in place.
// - Word reverse uses low bytes, sign-extends.
// - Double reverse covers all bytes unextended.
// - Overflow branch taken on signed 32-bit overflow.
// - No-overflow branch taken when no overflow.
// - Overflow when sum bit 32 differs bit 31.
// - Badly extended inputs count as overflow.
// - Input check ignores 64-bit enable state.
// - Zero source b checks source a well-formedness.
// - Both zero: overflow never, no-overflow always.
// - Overflow branch target uses shifted offset.
package cbbu_pkg;
  localparam int XLEN      = 64;
  localparam int INSN_BYTES = 4;
  localparam int OFF16_W   = 16;
  localparam int OFF21_W   = 21;
  localparam int OFF26_W   = 26;
  localparam int OFF_SHIFT = 1;
  localparam int WORD_W    = 32;
  localparam int SUM_HI    = 32;
  localparam int SUM_LO    = 31;

  typedef enum logic [4:0] {
    CBBU_OP_NONE               = 5'h00,
    CBBU_OP_BRANCH_EQ_REGS     = 5'h01,
    CBBU_OP_BRANCH_NE_REGS     = 5'h02,
    CBBU_OP_BRANCH_LT_SIGNED   = 5'h03,
    CBBU_OP_BRANCH_GE_SIGNED   = 5'h04,
    CBBU_OP_BRANCH_LT_UNSIGNED = 5'h05,
    CBBU_OP_BRANCH_GE_UNSIGNED = 5'h06,
    CBBU_OP_BRANCH_NEG         = 5'h07,
    CBBU_OP_BRANCH_NONPOSITIVE = 5'h08,
    CBBU_OP_BRANCH_NONNEGATIVE = 5'h09,
    CBBU_OP_BRANCH_POSITIVE    = 5'h0a,
    CBBU_OP_BRANCH_IS_ZERO     = 5'h0b,
    CBBU_OP_BRANCH_NOT_ZERO    = 5'h0c,
    CBBU_OP_SHORT_JUMP         = 5'h0d,
    CBBU_OP_BREAK              = 5'h0e,
    CBBU_OP_REVERSE_WORD       = 5'h0f,
    CBBU_OP_REVERSE_DOUBLE     = 5'h10,
    CBBU_OP_BRANCH_OVF         = 5'h11,
    CBBU_OP_BRANCH_NO_OVF      = 5'h12
  } cbbu_op_t;

  typedef enum logic [1:0] {
    CBBU_ST_IDLE   = 2'b00,
    CBBU_ST_RESULT = 2'b01,
    CBBU_ST_SQUASH = 2'b11
  } cbbu_state_t;
endpackage : cbbu_pkg

// ### cbbu_ovf_if.sv
`timescale 1ns/1ps
interface cbbu_ovf_if #(parameter int XLEN = 64) ();
  logic [XLEN-1:0] src_a;
  logic [XLEN-1:0] src_b;
  logic            ovf;
  modport checker_side (input src_a, input src_b, output ovf);
  modport user_side    (output src_a, output src_b, input ovf);
endinterface : cbbu_ovf_if

// ### cbbu_byte_rev.sv
`timescale 1ns/1ps
module cbbu_byte_rev (
  input  wire logic [7:0] din,
  output logic      [7:0] dout
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      dout[i] = din[7-i];
    end
  end
endmodule : cbbu_byte_rev

// ### cbbu_ovf_check.sv
`timescale 1ns/1ps
module cbbu_ovf_check (
  cbbu_ovf_if.checker_side ports
);
  localparam int W = cbbu_pkg::WORD_W;
  logic [W:0] sum_wide;
  logic       in_bad;
  // Wide sum of sign-extended low words
  assign sum_wide = {ports.src_a[W-1], ports.src_a[W-1:0]} + {ports.src_b[W-1], ports.src_b[W-1:0]};
  // Upper half must copy bit 31; no enable gate on purpose
  assign in_bad = (ports.src_a[63:W-1] != {33{ports.src_a[W-1]}}) ||
                  (ports.src_b[63:W-1] != {33{ports.src_b[W-1]}});
  assign ports.ovf = (sum_wide[cbbu_pkg::SUM_HI] != sum_wide[cbbu_pkg::SUM_LO]) || in_bad;
endmodule : cbbu_ovf_check

// ### cbbu_unit.sv
`timescale 1ns/1ps
module cbbu_unit #(
  parameter int XLEN = cbbu_pkg::XLEN
) (
  input  wire logic            ref_clk,
  input  wire logic            rst,
  input  wire logic            issue_valid,
  input  cbbu_pkg::cbbu_op_t   issue_op,
  input  wire logic [XLEN-1:0] issue_pc,
  input  wire logic [XLEN-1:0] source_a_val,
  input  wire logic [XLEN-1:0] source_b_val,
  input  wire logic [25:0]     issue_offset,
  input  wire logic            double_enable,
  output logic                 done_valid,
  output logic                 branch_taken,
  output logic [XLEN-1:0]      next_pc,
  output logic                 squash_next,
  output logic                 result_valid,
  output logic [XLEN-1:0]      result_data,
  output logic                 break_exc,
  output logic                 reserved_exc,
  output logic                 issue_ready
);
  ////////////////////////////////////////////////////////////////////////////
  logic [XLEN-1:0] rev_all;
  logic            ovf;
  logic            cond;
  logic            is_branch;
  logic [XLEN-1:0] seq_pc;
  logic [XLEN-1:0] off_ext;
  logic signed [XLEN-1:0] sa;
  logic signed [XLEN-1:0] sb;
  cbbu_pkg::cbbu_state_t state_q;

  genvar g;
  generate
    for (g = 0; g < XLEN / 8; g++) begin : g_rev
      cbbu_byte_rev u_rev (
        .din  (source_b_val[8*g +: 8]),
        .dout (rev_all[8*g +: 8])
      );
    end
  endgenerate

  cbbu_ovf_if #(.XLEN(XLEN)) ovf_bus ();
  assign ovf_bus.src_a = source_a_val;
  assign ovf_bus.src_b = source_b_val;
  assign ovf = ovf_bus.ovf;
  cbbu_ovf_check u_ovf (
    .ports (ovf_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign sa = source_a_val;
  assign sb = source_b_val;
  assign seq_pc = issue_pc + XLEN'(cbbu_pkg::INSN_BYTES);
  // No delay-slot restriction: always ready, one op per cycle
  assign issue_ready = 1'b1;

  always_comb begin
    cond      = 1'b0;
    is_branch = 1'b1;
    off_ext   = {{(XLEN-cbbu_pkg::OFF16_W){issue_offset[15]}}, issue_offset[15:0]};
    case (issue_op)
      cbbu_pkg::CBBU_OP_BRANCH_EQ_REGS:     cond = source_a_val == source_b_val;
      cbbu_pkg::CBBU_OP_BRANCH_NE_REGS:     cond = source_a_val != source_b_val;
      cbbu_pkg::CBBU_OP_BRANCH_LT_SIGNED:   cond = sa < sb;
      cbbu_pkg::CBBU_OP_BRANCH_GE_SIGNED:   cond = sa >= sb;
      cbbu_pkg::CBBU_OP_BRANCH_LT_UNSIGNED: cond = source_a_val < source_b_val;
      cbbu_pkg::CBBU_OP_BRANCH_GE_UNSIGNED: cond = source_a_val >= source_b_val;
      cbbu_pkg::CBBU_OP_BRANCH_NEG:         cond = sb < 0;
      cbbu_pkg::CBBU_OP_BRANCH_NONPOSITIVE: cond = sb <= 0;
      cbbu_pkg::CBBU_OP_BRANCH_NONNEGATIVE: cond = sb >= 0;
      cbbu_pkg::CBBU_OP_BRANCH_POSITIVE:    cond = sb > 0;
      cbbu_pkg::CBBU_OP_BRANCH_IS_ZERO: begin
        cond    = source_a_val == '0;
        off_ext = {{(XLEN-cbbu_pkg::OFF21_W){issue_offset[20]}}, issue_offset[20:0]};
      end
      cbbu_pkg::CBBU_OP_BRANCH_NOT_ZERO: begin
        cond    = source_a_val != '0;
        off_ext = {{(XLEN-cbbu_pkg::OFF21_W){issue_offset[20]}}, issue_offset[20:0]};
      end
      cbbu_pkg::CBBU_OP_SHORT_JUMP: begin
        cond    = 1'b1;
        off_ext = {{(XLEN-cbbu_pkg::OFF26_W){issue_offset[25]}}, issue_offset};
      end
      // Zero registers fall out of the checker naturally
      cbbu_pkg::CBBU_OP_BRANCH_OVF:    cond = ovf;
      cbbu_pkg::CBBU_OP_BRANCH_NO_OVF: cond = !ovf;
      default: is_branch = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      done_valid   <= 1'b0;
      branch_taken <= 1'b0;
      next_pc      <= '0;
    end else begin
      done_valid   <= issue_valid;
      branch_taken <= issue_valid && is_branch && cond;
      if (issue_valid) begin
        // Shift by one: halfword-aligned compressed targets
        next_pc <= (is_branch && cond) ? seq_pc + (off_ext << cbbu_pkg::OFF_SHIFT) : seq_pc;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      break_exc    <= 1'b0;
      reserved_exc <= 1'b0;
    end else begin
      break_exc    <= issue_valid && issue_op == cbbu_pkg::CBBU_OP_BREAK;
      reserved_exc <= issue_valid && issue_op == cbbu_pkg::CBBU_OP_REVERSE_DOUBLE && !double_enable;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result_valid <= 1'b0;
      result_data  <= '0;
    end else begin
      result_valid <= issue_valid && (issue_op == cbbu_pkg::CBBU_OP_REVERSE_WORD ||
                      (issue_op == cbbu_pkg::CBBU_OP_REVERSE_DOUBLE && double_enable));
      if (issue_valid && issue_op == cbbu_pkg::CBBU_OP_REVERSE_WORD) begin
        result_data <= {{(XLEN-32){rev_all[31]}}, rev_all[31:0]};
      end else if (issue_valid && issue_op == cbbu_pkg::CBBU_OP_REVERSE_DOUBLE && double_enable) begin
        result_data <= rev_all;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= cbbu_pkg::CBBU_ST_IDLE;
    end else begin
      case (state_q)
        cbbu_pkg::CBBU_ST_IDLE,
        cbbu_pkg::CBBU_ST_RESULT,
        cbbu_pkg::CBBU_ST_SQUASH: begin
          if (issue_valid && is_branch && cond) state_q <= cbbu_pkg::CBBU_ST_SQUASH;
          else if (issue_valid) state_q <= cbbu_pkg::CBBU_ST_RESULT;
          else state_q <= cbbu_pkg::CBBU_ST_IDLE;
        end
        default: state_q <= cbbu_pkg::CBBU_ST_IDLE;
      endcase
    end
  end

  // Squash comes from the state flop, so it cannot glitch into fetch
  assign squash_next = (state_q == cbbu_pkg::CBBU_ST_SQUASH);

  ////////////////////////////////////////////////////////////////////////////
  // Each check but a_squash_taken and a_idle_quiet judges the outputs one edge after the issue
  a_jump_always: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_SHORT_JUMP
    |=> branch_taken && squash_next)
    else $error("short jump not taken");
  a_squash_taken: assert property (@(posedge ref_clk) disable iff (rst)
    squash_next == branch_taken)
    else $error("squash differs from taken");
  a_not_taken_pc: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid ##1 !branch_taken
    |-> next_pc == $past(issue_pc) + 64'h4)
    else $error("fallthrough pc wrong");
  a_eq_branch: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_EQ_REGS
    |=> branch_taken == $past(source_a_val == source_b_val))
    else $error("equal branch wrong");
  a_ne_branch: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_NE_REGS
    |=> branch_taken == $past(source_a_val != source_b_val))
    else $error("not equal branch wrong");
  a_lt_branch: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_LT_SIGNED
    |=> branch_taken == $past($signed(source_a_val) < $signed(source_b_val)))
    else $error("signed lt wrong");
  a_ge_branch: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_GE_SIGNED
    |=> branch_taken == $past($signed(source_a_val) >= $signed(source_b_val)))
    else $error("signed ge wrong");
  a_ult_branch: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_LT_UNSIGNED
    |=> branch_taken == $past(source_a_val < source_b_val))
    else $error("unsigned lt wrong");
  a_uge_branch: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_GE_UNSIGNED
    |=> branch_taken == $past(source_a_val >= source_b_val))
    else $error("unsigned ge wrong");
  a_neg_branch: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_NEG
    |=> branch_taken == $past(source_b_val[63]))
    else $error("negative branch wrong");
  a_nonpos_branch: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_NONPOSITIVE
    |=> branch_taken == $past(source_b_val[63] || source_b_val == 64'h0))
    else $error("nonpositive branch wrong");
  a_nonneg_branch: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_NONNEGATIVE
    |=> branch_taken == $past(!source_b_val[63]))
    else $error("nonnegative branch wrong");
  a_pos_branch: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_POSITIVE
    |=> branch_taken == $past(!source_b_val[63] && source_b_val != 64'h0))
    else $error("positive branch wrong");
  a_zero_branch: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_IS_ZERO
    |=> branch_taken == $past(source_a_val == 64'h0))
    else $error("zero branch wrong");
  a_nonzero_branch: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_NOT_ZERO
    |=> branch_taken == $past(source_a_val != 64'h0))
    else $error("nonzero branch wrong");

  a_taken_pc: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_EQ_REGS ##1 branch_taken
    |-> next_pc == $past(issue_pc) + 64'h4 + {{47{$past(issue_offset[15])}}, $past(issue_offset[15:0]), 1'b0})
    else $error("taken target wrong");
  a_zero_target: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_IS_ZERO ##1 branch_taken
    |-> next_pc == $past(issue_pc) + 64'h4 + {{42{$past(issue_offset[20])}}, $past(issue_offset[20:0]), 1'b0})
    else $error("large offset target wrong");
  a_jump_target: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_SHORT_JUMP
    |=> next_pc == $past(issue_pc) + 64'h4 + {{37{$past(issue_offset[25])}}, $past(issue_offset), 1'b0})
    else $error("jump target wrong");
  a_ovf_target: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_OVF ##1 branch_taken
    |-> next_pc == $past(issue_pc) + 64'h4 + {{47{$past(issue_offset[15])}}, $past(issue_offset[15:0]), 1'b0})
    else $error("overflow target wrong");
  a_issue_done: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid
    |=> done_valid)
    else $error("issue not answered");
  a_idle_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    !issue_valid
    |=> !done_valid && !branch_taken && !result_valid && !break_exc && !reserved_exc)
    else $error("pulse without issue");

  a_break_trap: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BREAK
    |=> break_exc && !branch_taken)
    else $error("break not raised");
  a_break_code: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BREAK
    |=> next_pc == $past(issue_pc) + 64'h4 && !squash_next)
    else $error("break moved the pc");
  a_word_rev: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_REVERSE_WORD
    |=> result_valid && result_data[7] == $past(source_b_val[0]) && result_data[63:32] == {32{result_data[31]}})
    else $error("word reverse wrong");
  a_word_msb: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_REVERSE_WORD
    |=> result_data[24] == $past(source_b_val[31]) && result_data[31] == $past(source_b_val[24]))
    else $error("word top byte wrong");
  a_double_rev: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_REVERSE_DOUBLE && double_enable
    |=> result_valid && !reserved_exc && result_data[56] == $past(source_b_val[63]) &&
        result_data[63] == $past(source_b_val[56]))
    else $error("double reverse wrong");
  a_double_rsvd: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_REVERSE_DOUBLE && !double_enable
    |=> reserved_exc && !result_valid)
    else $error("reserved not raised");

  a_ovf_taken: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_OVF &&
    source_a_val == 64'h000000007fffffff && source_b_val == 64'h1
    |=> branch_taken)
    else $error("positive overflow missed");
  a_ovf_negsum: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_OVF &&
    source_a_val == 64'hffffffffffffffff && source_b_val == 64'hffffffff80000000
    |=> branch_taken)
    else $error("negative overflow missed");
  a_ovf_sum: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_NO_OVF &&
    source_a_val == 64'h000000007fffffff && source_b_val == 64'h1
    |=> !branch_taken)
    else $error("overflow missed");
  a_nvf_taken: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_NO_OVF &&
    source_a_val == 64'h1 && source_b_val == 64'h1
    |=> branch_taken)
    else $error("no overflow branch not taken");
  a_bad_input: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_OVF && source_b_val == 64'h0 &&
    source_a_val == 64'h0000000080000000
    |=> branch_taken)
    else $error("bad input not overflow");
  a_upper_bad: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_OVF && source_b_val == 64'h0 &&
    source_a_val == 64'h0000000100000000
    |=> branch_taken)
    else $error("upper bits not checked");
  a_good_input: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_NO_OVF && source_b_val == 64'h0 &&
    source_a_val == 64'hfffffffffffffffd
    |=> branch_taken)
    else $error("good input flagged");
  a_zero_ovf: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_OVF && source_a_val == 64'h0 && source_b_val == 64'h0
    |=> !branch_taken)
    else $error("overflow branch with zeros taken");
  a_zero_nvf: assert property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_NO_OVF && source_a_val == 64'h0 && source_b_val == 64'h0
    |=> branch_taken)
    else $error("no overflow branch with zeros not taken");

  c_taken: cover property (@(posedge ref_clk) disable iff (rst) branch_taken ##1 branch_taken);
  c_ovf: cover property (@(posedge ref_clk) disable iff (rst)
    issue_valid && issue_op == cbbu_pkg::CBBU_OP_BRANCH_OVF && ovf);
  c_dbl: cover property (@(posedge ref_clk) disable iff (rst) result_valid && double_enable);
  c_b2b: cover property (@(posedge ref_clk) disable iff (rst) issue_valid ##1 issue_valid && branch_taken);
  c_rsvd: cover property (@(posedge ref_clk) disable iff (rst) reserved_exc);
endmodule : cbbu_unit

// ### cbbu_pipe_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Far-side pipeline: drops one fetched slot per cycle that squash is high
module cbbu_pipe_model (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       done_valid,
  input  wire logic       squash_next,
  input  wire logic       issue_ready,
  output logic      [7:0] n_squash
);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      n_squash <= 8'h00;
    end else if (done_valid && squash_next && issue_ready) begin
      n_squash <= n_squash + 8'h01;
    end
  end
endmodule : cbbu_pipe_model

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  logic ref_clk, rst, iv, de, dv, bt, sq, rv_o, bx, rx, rdy;
  cbbu_pkg::cbbu_op_t op;
  logic [63:0] pc, a, b, npc, res;
  logic [25:0] off;
  logic [7:0]  nsq;
  int          n_fail, checks, nsq_exp;
  cbbu_unit cbbu_unit_i (.ref_clk(ref_clk), .rst(rst), .issue_valid(iv), .issue_op(op), .issue_pc(pc),
    .source_a_val(a), .source_b_val(b), .issue_offset(off), .double_enable(de), .done_valid(dv),
    .branch_taken(bt), .next_pc(npc), .squash_next(sq), .result_valid(rv_o), .result_data(res),
    .break_exc(bx), .reserved_exc(rx), .issue_ready(rdy));
  cbbu_pipe_model cbbu_pipe_model_i (.ref_clk(ref_clk), .rst(rst), .done_valid(dv), .squash_next(sq),
    .issue_ready(rdy), .n_squash(nsq));
  ////////////////////////////////////////////////////////////////
  task c64(input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : c64
  task c1(input logic e, input logic g);
    c64({63'h0, e}, {63'h0, g});
  endtask : c1
  function automatic logic [63:0] tg(input logic [25:0] f, input int w);
    logic [63:0] s;
    s = {38'h0, f} << (64 - w);
    s = $signed(s) >>> (64 - w);
    return 64'h1004 + (s << 1);
  endfunction : tg
  function automatic logic [63:0] rvb(input logic [63:0] x);
    logic [63:0] r;
    for (int i = 0; i < 64; i++) r[i] = x[(i / 8) * 8 + 7 - i % 8];
    return r;
  endfunction : rvb
  task go(input cbbu_pkg::cbbu_op_t o, input logic [63:0] x, input logic [63:0] y, input logic [25:0] f);
    int k;
    @(posedge ref_clk);
    iv <= 1'b1; op <= o; a <= x; b <= y; off <= f;
    @(posedge ref_clk);
    iv <= 1'b0;
    #1;
    k = 0;
    // Bounded wait so a silent design cannot hang the run
    while (dv !== 1'b1 && k < 3) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    c1(1'b1, dv);
    c1(1'b1, rdy);
  endtask : go
  task br(input cbbu_pkg::cbbu_op_t o, input logic [63:0] x, input logic [63:0] y, input logic [25:0] f,
          input logic t, input int w);
    go(o, x, y, f);
    c1(t, bt);
    c1(t, sq);
    c64(t ? tg(f, w) : 64'h1004, npc);
    if (t) nsq_exp++;
  endtask : br
  ////////////////////////////////////////////////////////////////
  task t_regs;
    br(cbbu_pkg::CBBU_OP_BRANCH_EQ_REGS, '1, 64'h1, 26'h0008, 1'b0, 16);
    br(cbbu_pkg::CBBU_OP_BRANCH_EQ_REGS, 64'h5, 64'h5, 26'h8000, 1'b1, 16);
    br(cbbu_pkg::CBBU_OP_BRANCH_NE_REGS, '1, 64'h1, 26'h3f7fff, 1'b1, 16);
    br(cbbu_pkg::CBBU_OP_BRANCH_LT_SIGNED, '1, 64'h1, 26'h0010, 1'b1, 16);
    br(cbbu_pkg::CBBU_OP_BRANCH_GE_SIGNED, '1, 64'h1, 26'h0010, 1'b0, 16);
    br(cbbu_pkg::CBBU_OP_BRANCH_GE_SIGNED, 64'h1, 64'h1, 26'h0010, 1'b1, 16);
    br(cbbu_pkg::CBBU_OP_BRANCH_LT_UNSIGNED, '1, 64'h1, 26'h0010, 1'b0, 16);
    br(cbbu_pkg::CBBU_OP_BRANCH_GE_UNSIGNED, '1, 64'h1, 26'h0010, 1'b1, 16);
  endtask : t_regs
  task t_zero;
    br(cbbu_pkg::CBBU_OP_BRANCH_NEG, 64'h0, -64'sd5, 26'h0004, 1'b1, 16);
    br(cbbu_pkg::CBBU_OP_BRANCH_NONPOSITIVE, 64'h1, 64'h0, 26'h0004, 1'b1, 16);
    br(cbbu_pkg::CBBU_OP_BRANCH_NONNEGATIVE, 64'h0, -64'sd5, 26'h0004, 1'b0, 16);
    br(cbbu_pkg::CBBU_OP_BRANCH_POSITIVE, 64'h0, 64'h0, 26'h0004, 1'b0, 16);
    br(cbbu_pkg::CBBU_OP_BRANCH_POSITIVE, 64'h0, 64'h1, 26'h0004, 1'b1, 16);
    br(cbbu_pkg::CBBU_OP_BRANCH_IS_ZERO, 64'h0, 64'h7, 26'h100000, 1'b1, 21);
    br(cbbu_pkg::CBBU_OP_BRANCH_NOT_ZERO, 64'h0, 64'h7, 26'h0fffff, 1'b0, 21);
    br(cbbu_pkg::CBBU_OP_BRANCH_NOT_ZERO, 64'h2, 64'h0, 26'h0fffff, 1'b1, 21);
  endtask : t_zero
  task t_misc;
    br(cbbu_pkg::CBBU_OP_SHORT_JUMP, 64'h0, 64'h0, 26'h3ffffff, 1'b1, 26);
    br(cbbu_pkg::CBBU_OP_BREAK, 64'h0, 64'h0, 26'h3ffffff, 1'b0, 26);
    c1(1'b1, bx);
    br(cbbu_pkg::CBBU_OP_NONE, 64'h5, 64'h5, 26'h0004, 1'b0, 16);
  endtask : t_misc
  task t_rev;
    logic [63:0] x;
    logic [63:0] r;
    x = 64'h0123_4567_89ab_cd01;
    r = rvb(x);
    de <= 1'b0;
    // The reversed value travels on source b
    go(cbbu_pkg::CBBU_OP_REVERSE_WORD, 64'h0, x, 26'h0);
    c1(1'b1, rv_o);
    c64({{32{r[31]}}, r[31:0]}, res);
    go(cbbu_pkg::CBBU_OP_REVERSE_DOUBLE, 64'h0, x, 26'h0);
    c1(1'b1, rx);
    c1(1'b0, rv_o);
    de <= 1'b1;
    go(cbbu_pkg::CBBU_OP_REVERSE_DOUBLE, 64'h0, x, 26'h0);
    c1(1'b0, rx);
    c1(1'b1, rv_o);
    c64(r, res);
  endtask : t_rev
  task t_ovf;
    // Enable off on purpose: the input check must not depend on it
    de <= 1'b0;
    br(cbbu_pkg::CBBU_OP_BRANCH_OVF, 64'h7fffffff, 64'h1, 26'h8002, 1'b1, 16);
    br(cbbu_pkg::CBBU_OP_BRANCH_NO_OVF, 64'h7fffffff, 64'h1, 26'h0002, 1'b0, 16);
    br(cbbu_pkg::CBBU_OP_BRANCH_OVF, '1, 64'hffffffff80000000, 26'h0002, 1'b1, 16);
    br(cbbu_pkg::CBBU_OP_BRANCH_NO_OVF, 64'h1, 64'h1, 26'h0002, 1'b1, 16);
    br(cbbu_pkg::CBBU_OP_BRANCH_OVF, 64'h1_0000_0000, 64'h0, 26'h0002, 1'b1, 16);
    br(cbbu_pkg::CBBU_OP_BRANCH_NO_OVF, 64'h1_0000_0000, 64'h0, 26'h0002, 1'b0, 16);
    br(cbbu_pkg::CBBU_OP_BRANCH_OVF, 64'h8000_0000, 64'h0, 26'h0002, 1'b1, 16);
    br(cbbu_pkg::CBBU_OP_BRANCH_NO_OVF, -64'sd3, 64'h0, 26'h0002, 1'b1, 16);
    br(cbbu_pkg::CBBU_OP_BRANCH_OVF, 64'h0, 64'h0, 26'h0002, 1'b0, 16);
    br(cbbu_pkg::CBBU_OP_BRANCH_NO_OVF, 64'h0, 64'h0, 26'h0002, 1'b1, 16);
  endtask : t_ovf
  task t_b2b;
    @(posedge ref_clk);
    iv <= 1'b1; op <= cbbu_pkg::CBBU_OP_SHORT_JUMP; off <= 26'h0002;
    // Jump, jump, break on three edges in a row
    @(posedge ref_clk);
    #1;
    c1(1'b1, bt);
    c64(64'h1008, npc);
    @(posedge ref_clk);
    op <= cbbu_pkg::CBBU_OP_BREAK;
    #1;
    c1(1'b1, bt);
    c1(1'b1, sq);
    @(posedge ref_clk);
    iv <= 1'b0;
    #1;
    c1(1'b1, dv);
    c1(1'b1, bx);
    c1(1'b0, bt);
    nsq_exp += 2;
  endtask : t_b2b
  ////////////////////////////////////////////////////////////////
  task test_done;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    #(20 * 3000);
    n_fail++;
    test_done;
  end
  initial begin
    n_fail = 0; checks = 0; nsq_exp = 0;
    rst = 1'b1; iv = 1'b0; de = 1'b0; op = cbbu_pkg::CBBU_OP_NONE;
    pc = 64'h1000; a = 64'h0; b = 64'h0; off = 26'h0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs;
    t_zero;
    t_misc;
    t_rev;
    t_ovf;
    t_b2b;
    repeat (2) @(posedge ref_clk);
    c64(64'(nsq_exp), {56'h0, nsq});
    test_done;
  end
endmodule : testbench
